/* core/err_queue_pkg.sv */
/*
 * Constants shared by the error queue: depth, code width and the
 * signed codes that the block itself raises.
 * Assumes nothing of its surroundings.
 */
package err_queue_pkg;
    localparam int DEPTH = 10;
    localparam int CODE_W = 11;
    localparam int CNT_W = 4;
    typedef logic signed [CODE_W-1:0] code_t;
    localparam code_t CODE_NO_ERROR = 11'sd0;
    localparam code_t CODE_QUE_OVERFLOW = -11'sd330;
    localparam code_t CODE_IN_OVERRUN = -11'sd350;
    localparam code_t CODE_SYNTAX = -11'sd102;
    localparam code_t CODE_UNDEF_HEADER = -11'sd113;
    localparam code_t CODE_CURR_LIMIT = 11'sd320;
    localparam code_t CODE_CURR_TRIP = 11'sd321;
    localparam code_t CODE_OVP = 11'sd410;
endpackage

/* core/err_src_if.sv */
/*
 * Carrier for the one-event-per-cycle path from the event selector
 * to the queue core. Assumes a single clock domain.
 */
`timescale 1ns/10ps
interface err_src_if;
    logic valid;
    err_queue_pkg::code_t code;
    modport src (output valid, output code);
    modport dst (input valid, input code);
endinterface

/* core/err_event_sel.sv */
/*
 * Event selector: turns event strobes into one code per cycle.
 * Assumes strobes are single-cycle pulses from the clk_sys_i domain.
 */
`timescale 1ns/10ps
module err_event_sel (
    input wire logic ext_valid_i,                   // generic code strobe
    input wire err_queue_pkg::code_t ext_code_i,    // generic code
    input wire logic syntax_err_i,                  // syntax fault
    input wire logic undef_header_i,                // unknown header
    input wire logic curr_limit_i,                  // limit, not tripped
    input wire logic curr_trip_i,                   // limit tripped
    input wire logic over_voltage_trip_i,           // ovp tripped
    err_src_if.src src                              // selected event
);
    // fixed priority; lower ones this cycle are dropped, a limitation
    assign src.valid = ext_valid_i | syntax_err_i | undef_header_i |
        curr_limit_i | curr_trip_i | over_voltage_trip_i;
    assign src.code = curr_trip_i ? err_queue_pkg::CODE_CURR_TRIP :
        curr_limit_i ? err_queue_pkg::CODE_CURR_LIMIT :
        over_voltage_trip_i ? err_queue_pkg::CODE_OVP :
        undef_header_i ? err_queue_pkg::CODE_UNDEF_HEADER :
        syntax_err_i ? err_queue_pkg::CODE_SYNTAX :
        ext_code_i;
endmodule

/* core/error_message_queue.sv */
/*
 * Error/event message queue: ten signed codes, first in first out,
 * with overflow marker and lock. Assumes all inputs are same-clock
 * single-cycle strobes from command and protection logic.
 */
`timescale 1ns/10ps
module error_message_queue #(
    parameter int DEPTH = err_queue_pkg::DEPTH
) (
    input wire logic clk_sys_i,                     // 100 MHz clock
    input wire logic rstn_i,                        // power-up reset
    input wire logic ext_valid_i,                   // code strobe
    input wire err_queue_pkg::code_t ext_code_i,    // code to queue
    input wire logic syntax_err_i,                  // syntax fault
    input wire logic undef_header_i,                // unknown header
    input wire logic curr_limit_i,                  // limit event
    input wire logic curr_trip_i,                   // limit tripped
    input wire logic over_voltage_trip_i,           // ovp tripped
    input wire logic clear_i,                       // clear command
    input wire logic inst_reset_i,                  // instrument reset
    input wire logic rd_i,                          // read strobe
    output err_queue_pkg::code_t rd_code_o,         // read result
    output logic rd_valid_o,                        // result strobe
    output logic [err_queue_pkg::CNT_W-1:0] count_o, // occupancy
    output logic overflow_o                         // overflow lock
);
    // event selection kept apart so the core sees one code a cycle
    err_src_if ev ();

    err_event_sel u_sel (
        .ext_valid_i(ext_valid_i),
        .ext_code_i(ext_code_i),
        .syntax_err_i(syntax_err_i),
        .undef_header_i(undef_header_i),
        .curr_limit_i(curr_limit_i),
        .curr_trip_i(curr_trip_i),
        .over_voltage_trip_i(over_voltage_trip_i),
        .src(ev.src)
    );

    localparam int PW = err_queue_pkg::CNT_W;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW-1:0] FULLC = PW'(DEPTH);
    localparam logic [PW-1:0] ONE = PW'(1);
    localparam logic [PW-1:0] ZERO = PW'(0);

    // storage
    err_queue_pkg::code_t mem_q [DEPTH];

    // read pointer
    logic [PW-1:0] rp_q;
    logic [PW-1:0] rp_d;
    logic [PW-1:0] rp_next;

    // write pointer
    logic [PW-1:0] wp_q;
    logic [PW-1:0] wp_d;
    logic [PW-1:0] wp_next;
    logic [PW-1:0] newest;

    // occupancy
    logic [PW-1:0] cnt_q;
    logic [PW-1:0] cnt_d;
    logic [PW-1:0] cnt_up;
    logic [PW-1:0] cnt_dn;

    // overflow lock
    logic ovf_q;
    logic ovf_d;

    // read answer
    err_queue_pkg::code_t head;
    err_queue_pkg::code_t rdat_q;
    err_queue_pkg::code_t rdat_d;
    logic rv_q;
    logic rv_d;

    // decode
    logic empty;
    logic full;
    logic do_rd;
    logic do_wr;
    logic do_ovf;
    logic keep;

    // storage write port
    logic mem_wr;
    logic [PW-1:0] mem_addr;
    err_queue_pkg::code_t mem_data;

    // occupancy state
    assign empty = (cnt_q == ZERO);
    assign full = (cnt_q == FULLC);

    // a read of an empty queue is answered but moves nothing
    assign do_rd = rd_i & ~empty;

    // a read in the same cycle frees a slot, so the write fits
    assign do_wr = ev.valid & ~ovf_q & (~full | do_rd);
    assign do_ovf = ev.valid & ~ovf_q & full & ~do_rd;

    // clear wins over write and pointer moves of its own cycle; a read then still answers with the head
    assign keep = ~clear_i;

    // instrument reset has no path into queue state

    // pointer wrap at the documented depth
    assign rp_next = (rp_q == LAST) ? ZERO : rp_q + ONE;
    assign wp_next = (wp_q == LAST) ? ZERO : wp_q + ONE;
    assign newest = (wp_q == ZERO) ? LAST : wp_q - ONE;

    // next pointers
    assign rp_d = !keep ? ZERO : (do_rd ? rp_next : rp_q);
    assign wp_d = !keep ? ZERO : (do_wr ? wp_next : wp_q);

    // overflow replaces the newest entry, so the count stays put
    assign cnt_up = do_wr ? ONE : ZERO;
    assign cnt_dn = do_rd ? ONE : ZERO;
    assign cnt_d = !keep ? ZERO : cnt_q + cnt_up - cnt_dn;

    // lock holds until a clear
    assign ovf_d = keep & (ovf_q | do_ovf);

    // oldest entry is always at the read pointer
    assign head = mem_q[rp_q];
    assign rdat_d = do_rd ? head : err_queue_pkg::CODE_NO_ERROR;
    assign rv_d = rd_i;

    // marker or incoming code
    assign mem_wr = keep & (do_wr | do_ovf);
    assign mem_addr = do_wr ? wp_q : newest;
    assign mem_data = do_wr ? ev.code : err_queue_pkg::CODE_QUE_OVERFLOW;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rp_q <= ZERO;
        end else begin
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_q <= ZERO;
        end else begin
            wp_q <= wp_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdat_q <= err_queue_pkg::CODE_NO_ERROR;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rv_q <= 1'b0;
        end else begin
            rv_q <= rv_d;
        end
    end

    // storage has no reset; pointers define what is live
    always_ff @(posedge clk_sys_i) begin
        if (mem_wr) begin
            mem_q[mem_addr] <= mem_data;
        end
    end

    // outputs straight from flip-flops
    assign rd_code_o = rdat_q;
    assign rd_valid_o = rv_q;
    assign count_o = cnt_q;
    assign overflow_o = ovf_q;
endmodule

/* tb/err_queue_properties.sv */
/* queue port checker; assumes binding to error_message_queue */
`timescale 1ns/10ps
module err_queue_properties (
    input wire logic clk_sys_i, // clock
    input wire logic rstn_i, // reset
    input wire logic ext_valid_i, // write
    input wire logic syntax_err_i, // event
    input wire logic undef_header_i, // event
    input wire logic curr_limit_i, // event
    input wire logic curr_trip_i, // event
    input wire logic over_voltage_trip_i, // event
    input wire logic clear_i, // clear
    input wire logic rd_i, // read
    input wire err_queue_pkg::code_t rd_code_o, // code
    input wire logic rd_valid_o, // code strobe
    input wire logic [3:0] count_o, // fill
    input wire logic overflow_o // lock
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    wire logic any_ev = ext_valid_i | syntax_err_i | undef_header_i |
        curr_limit_i | curr_trip_i | over_voltage_trip_i;
    wire logic wr = any_ev && !rd_i && !clear_i && !overflow_o;
    property p_rv; 1 |=> rd_valid_o == $past(rd_i); endproperty
    a_rv: assert property (p_rv) else $error("rd_valid");
    property p_emp; rd_i && count_o == 4'h0 |=> rd_code_o == 11'h000;
    endproperty
    a_emp: assert property (p_emp) else $error("empty code");
    property p_dec; rd_i && !any_ev && !clear_i && count_o != 4'h0
        |=> count_o == $past(count_o) - 4'h1; endproperty
    a_dec: assert property (p_dec) else $error("read count");
    property p_inc; wr && count_o < 4'hA
        |=> count_o == $past(count_o) + 4'h1; endproperty
    a_inc: assert property (p_inc) else $error("write count");
    property p_ovf; wr && count_o == 4'hA |=> overflow_o && count_o == 4'hA;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow");
    property p_lock; overflow_o && !clear_i && !rd_i
        |=> overflow_o && $stable(count_o); endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_clr; clear_i |=> !overflow_o && count_o == 4'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_max; count_o <= 4'hA; endproperty
    a_max: assert property (p_max) else $error("count range");
    c_ovf: cover property ($rose(overflow_o));
    c_emp: cover property (rd_i && count_o == 4'h0);
    c_clr: cover property (clear_i && overflow_o);
endmodule
bind error_message_queue err_queue_properties u_err_queue_properties (
    .clk_sys_i, .rstn_i, .ext_valid_i, .syntax_err_i, .undef_header_i,
    .curr_limit_i, .curr_trip_i, .over_voltage_trip_i, .clear_i, .rd_i,
    .rd_code_o, .rd_valid_o, .count_o, .overflow_o);

/* tb/err_reader.sv */
/* remote controller model issuing single reads; same clock as queue */
`timescale 1ns/10ps
module err_reader (
    input wire logic clk_sys_i, // clock
    output logic rd_o, // read strobe
    input wire logic rd_valid_i, // answer strobe
    input wire err_queue_pkg::code_t rd_code_i // answer code
);
    initial rd_o = 1'b0;
    // answer taken at falling edge, where it stands settled
    task automatic read(output err_queue_pkg::code_t c);
        @(negedge clk_sys_i) rd_o = 1'b1;
        @(negedge clk_sys_i) c = rd_valid_i ? rd_code_i : 'x;
        rd_o = 1'b0;
    endtask
endmodule

/* tb/tb_top.sv */
/* queue testbench: strobes at falling edges, reads via controller
   model; assumes one 100 MHz clock */
`timescale 1ns/10ps
module tb_top;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] m = 8'h00;
    logic rd_i, rd_valid_o, overflow_o;
    logic [3:0] count_o;
    err_queue_pkg::code_t ext_code_i = 11'h000, rd_code_o, got;
    logic [10:0] exp_c[6] = '{11'h79A, 11'h78F, 11'h140, 11'h141,
        11'h19A, 11'h6A2};
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    initial forever #5 clk_sys_i = ~clk_sys_i;
    error_message_queue u_error_message_queue (.clk_sys_i, .rstn_i,
        .ext_valid_i(m[5]), .ext_code_i, .syntax_err_i(m[0]),
        .undef_header_i(m[1]), .curr_limit_i(m[2]), .curr_trip_i(m[3]),
        .over_voltage_trip_i(m[4]), .clear_i(m[6]), .inst_reset_i(m[7]),
        .rd_i, .rd_code_o, .rd_valid_o, .count_o, .overflow_o);
    err_reader u_err_reader (.clk_sys_i, .rd_o(rd_i),
        .rd_valid_i(rd_valid_o), .rd_code_i(rd_code_o));
    task automatic chk(string n, logic [10:0] e, logic [10:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic put(logic [7:0] v, err_queue_pkg::code_t c);
        @(negedge clk_sys_i) m = v;
        ext_code_i = c;
        @(negedge clk_sys_i) m = 8'h00;
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_codes();
        for (int i = 0; i < 5; i++)
            put(8'h01 << i, 11'h000);
        put(8'h20, 11'h6A2);
        chk("count", 11'h006, {7'h00, count_o});
        for (int i = 0; i < 6; i++) begin
            u_err_reader.read(got);
            chk("code", exp_c[i], got);
        end
        u_err_reader.read(got);
        chk("empty", 11'h000, got);
        chk("count", 11'h000, {7'h00, count_o});
        $display("t_codes done");
    endtask
    task automatic t_ovf();
        for (int i = 1; i <= 11; i++)
            put(8'h20, 11'(i));
        chk("ovf", 11'h001, {10'h000, overflow_o});
        put(8'h80, 11'h000);
        chk("count", 11'h00A, {7'h00, count_o});
        chk("ovf_kept", 11'h001, {10'h000, overflow_o});
        for (int i = 1; i <= 10; i++) begin
            u_err_reader.read(got);
            chk("code", i < 10 ? 11'(i) : 11'h6B6, got);
        end
        put(8'h20, 11'h00C);
        chk("locked", 11'h000, {7'h00, count_o});
        put(8'h40, 11'h000);
        chk("clear", 11'h000, {10'h000, overflow_o});
        put(8'h20, 11'h00D);
        chk("unlocked", 11'h001, {7'h00, count_o});
        $display("t_ovf done");
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        t_codes();
        t_ovf();
        end_sim();
    end
endmodule
